// ---- design/uim_top.sv ----
// Purpose: interrupt enable, disable, view and status registers
// Assumes: AXI4-Lite slave, one write and one read under way at a time
// Notes: instance base chosen by parameter, offsets decoded in low bits
//
// Functional notes
// - writing one to a disable bit disables that source
// - view register read-only, one means source enabled
// - all enable bits read zero after reset
// - bits 31 to 13 ignored on write, read zero
// - common bit order, 12 tx overflow down to 0 rx trigger
// - two instances at two bases, registers at 0x08 to 0x14
// - writing one to an enable bit enables that source
//
// Chosen here: the AXI4-Lite slave port.
`include "uim_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module uim_top #(
    parameter logic [31:0] BASE_ADDR = `UIM_BASE_FIRST
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`UIM_SRC_W-1:0] event_pulse,
    output logic irq
);
    // ****************************************
    // write channel
    // ****************************************
    uim_pkg::uim_wstate_e wst_r, wst_nxt;
    logic aw_held_r, aw_held_nxt;
    logic w_held_r, w_held_nxt;
    logic [31:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic set_stb, clr_stb, sts_stb;
    uim_pkg::uim_src_t wr_bits;
    uim_pkg::uim_src_t enabled;
    uim_pkg::uim_src_t status_r, status_nxt;
    logic do_write;
    logic [`UIM_OFF_W-1:0] woff;
    logic wbase_ok;

    assign s_axi_awready = (wst_r == uim_pkg::UIM_W_IDLE) && !aw_held_r;
    assign s_axi_wready = (wst_r == uim_pkg::UIM_W_IDLE) && !w_held_r;
    assign s_axi_bvalid = (wst_r == uim_pkg::UIM_W_RESP);
    assign s_axi_bresp = bresp_r;

    always_comb begin
        wst_nxt = wst_r;
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        do_write = 1'b0;
        case (wst_r)
            uim_pkg::UIM_W_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_nxt = 1'b1;
                    awaddr_nxt = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_nxt = 1'b1;
                    wdata_nxt = s_axi_wdata;
                    wstrb_nxt = s_axi_wstrb;
                end
                if (aw_held_r && w_held_r) begin
                    do_write = 1'b1;
                    aw_held_nxt = 1'b0;
                    w_held_nxt = 1'b0;
                    wst_nxt = uim_pkg::UIM_W_RESP;
                end
            end
            uim_pkg::UIM_W_RESP: begin
                if (s_axi_bready) begin
                    wst_nxt = uim_pkg::UIM_W_IDLE;
                end
            end
            default: begin
                wst_nxt = uim_pkg::UIM_W_IDLE;
            end
        endcase
    end

    // decode, only the instance window is claimed
    always_comb begin
        woff = awaddr_r[`UIM_OFF_W-1:0];
        wbase_ok = (awaddr_r[31:`UIM_OFF_W] ==
            BASE_ADDR[31:`UIM_OFF_W]);
        set_stb = 1'b0;
        clr_stb = 1'b0;
        sts_stb = 1'b0;
        if (!do_write) begin
            bresp_nxt = bresp_r;
        end else if (wbase_ok && woff == `UIM_OFF_ENABLE) begin
            set_stb = 1'b1;
            bresp_nxt = `UIM_RESP_OKAY;
        end else if (wbase_ok && woff == `UIM_OFF_DISABLE) begin
            clr_stb = 1'b1;
            bresp_nxt = `UIM_RESP_OKAY;
        end else if (wbase_ok && woff == `UIM_OFF_STATUS) begin
            sts_stb = 1'b1;
            bresp_nxt = `UIM_RESP_OKAY;
        end else if (wbase_ok && woff == `UIM_OFF_VIEW) begin
            // read-only view: write accepted and dropped
            bresp_nxt = `UIM_RESP_OKAY;
        end else begin
            bresp_nxt = `UIM_RESP_SLVERR;
        end
    end

    // upper bits never reach the enable logic; lanes gate the low bits
    assign wr_bits = wdata_r[`UIM_SRC_W-1:0] &
        {{5{wstrb_r[1]}}, {8{wstrb_r[0]}}};

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wst_r <= uim_pkg::UIM_W_IDLE;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 32'h0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bresp_r <= `UIM_RESP_OKAY;
        end else begin
            wst_r <= wst_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // ****************************************
    // enable bits and interrupt
    // ****************************************
    uim_enable_reg u_en (
        .clk(clk),
        .nrst(nrst),
        .set_stb(set_stb),
        .clr_stb(clr_stb),
        .wr_bits(wr_bits),
        .enabled(enabled)
    );

    // sticky events, write one clears, a new event wins over its clear
    always_comb begin
        status_nxt = status_r;
        if (sts_stb) begin
            status_nxt = status_nxt & ~wr_bits;
        end
        status_nxt = status_nxt | event_pulse;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            status_r <= `UIM_SRC_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    uim_irq_gate u_irq (
        .clk(clk),
        .nrst(nrst),
        .status(status_r),
        .enabled(enabled),
        .irq(irq)
    );

    // ****************************************
    // read channel
    // ****************************************
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [`UIM_OFF_W-1:0] roff;
    logic rbase_ok;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        roff = s_axi_araddr[`UIM_OFF_W-1:0];
        rbase_ok = (s_axi_araddr[31:`UIM_OFF_W] ==
            BASE_ADDR[31:`UIM_OFF_W]);
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = 32'h0;
            rresp_nxt = `UIM_RESP_OKAY;
            if (rbase_ok && roff == `UIM_OFF_VIEW) begin
                rdata_nxt[`UIM_SRC_W-1:0] = enabled;
            end else if (rbase_ok && roff == `UIM_OFF_STATUS) begin
                rdata_nxt[`UIM_SRC_W-1:0] = status_r;
            end else if (rbase_ok && (roff == `UIM_OFF_ENABLE ||
                roff == `UIM_OFF_DISABLE)) begin
                // write-only registers read as zero
                rdata_nxt = 32'h0;
            end else begin
                rresp_nxt = `UIM_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= `UIM_RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_enable_write;
        set_stb && !clr_stb;
    endsequence
    sequence s_disable_write;
        clr_stb;
    endsequence
    sequence s_status_write;
        sts_stb;
    endsequence

    a_enable_sets: assert property (@(posedge clk)
        disable iff (!nrst)
        s_enable_write |=> ((enabled & $past(wr_bits)) == $past(wr_bits)))
        else $error("enable write did not enable source");
    a_disable_clears: assert property (@(posedge clk)
        disable iff (!nrst)
        s_disable_write |=> ((enabled & $past(wr_bits)) == '0))
        else $error("disable write did not disable source");
    a_reset_zero: assert property (@(posedge clk)
        !nrst |=> (enabled == '0 && !irq))
        else $error("enable bits not zero after reset");
    a_view_read: assert property (@(posedge clk)
        disable iff (!nrst)
        (s_axi_arvalid && s_axi_arready && rbase_ok &&
        roff == `UIM_OFF_VIEW) |=>
        (rdata_r == {19'h0, $past(enabled)}))
        else $error("view read differs from enable bits");
    a_upper_zero: assert property (@(posedge clk)
        disable iff (!nrst)
        rvalid_r |-> (rdata_r[31:`UIM_SRC_W] == '0))
        else $error("upper read bits not zero");
    a_view_ro: assert property (@(posedge clk)
        disable iff (!nrst)
        (!set_stb && !clr_stb) |=> $stable(enabled))
        else $error("enable bits changed without a write");
    a_bit_order: assert property (@(posedge clk)
        disable iff (!nrst)
        (set_stb && !clr_stb && wr_bits[uim_pkg::UIM_TX_OVR]) |=>
        enabled[uim_pkg::UIM_TX_OVR])
        else $error("tx overflow bit not at its position");
    a_write_resp: assert property (@(posedge clk)
        disable iff (!nrst)
        (aw_held_r && w_held_r && wst_r == uim_pkg::UIM_W_IDLE) |=>
        s_axi_bvalid)
        else $error("write response missing");
    a_bad_addr: assert property (@(posedge clk)
        disable iff (!nrst)
        (do_write && !wbase_ok) |=>
        (s_axi_bvalid && s_axi_bresp == `UIM_RESP_SLVERR))
        else $error("write outside the window not refused");
    a_resp_once: assert property (@(posedge clk)
        disable iff (!nrst)
        (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
        else $error("write response held past its handshake");
    a_read_once: assert property (@(posedge clk)
        disable iff (!nrst)
        (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
        else $error("read data held past its handshake");
    a_event_sets: assert property (@(posedge clk)
        disable iff (!nrst)
        (event_pulse != '0) |=>
        ((status_r & $past(event_pulse)) == $past(event_pulse)))
        else $error("event did not set its status bit");
    a_status_clears: assert property (@(posedge clk)
        disable iff (!nrst)
        s_status_write |=>
        ((status_r & $past(wr_bits) & ~$past(event_pulse)) == '0))
        else $error("status write of one did not clear the bit");
endmodule // uim_top
`default_nettype wire

// ---- design/uim_cfg.svh ----
// Purpose: constants for the serial port interrupt mask block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: one controller instance per module copy
`ifndef UIM_CFG_SVH
`define UIM_CFG_SVH
// ****************************************
// register map
// ****************************************
`define UIM_BASE_FIRST 32'he0000000
`define UIM_BASE_SECOND 32'he0001000
`define UIM_OFF_ENABLE 12'h008
`define UIM_OFF_DISABLE 12'h00c
`define UIM_OFF_VIEW 12'h010
`define UIM_OFF_STATUS 12'h014
`define UIM_SRC_W 13
`define UIM_SRC_RESET 13'h0000
`define UIM_OFF_W 12
// ****************************************
// bus responses
// ****************************************
`define UIM_RESP_OKAY 2'h0
`define UIM_RESP_SLVERR 2'h2
`endif

// ---- design/uim_pkg.sv ----
// Purpose: types for the serial port interrupt mask block
// Assumes: nothing
// Notes: source bit positions listed in the enum
`include "uim_cfg.svh"
package uim_pkg;
    typedef logic [`UIM_SRC_W-1:0] uim_src_t;
    typedef enum logic [3:0] {
        UIM_RX_TRIG = 4'h0, UIM_RX_EMPTY = 4'h1, UIM_RX_FULL = 4'h2,
        UIM_TX_EMPTY = 4'h3, UIM_TX_FULL = 4'h4, UIM_RX_OVR = 4'h5,
        UIM_FRAME = 4'h6, UIM_PARITY = 4'h7, UIM_RX_TOUT = 4'h8,
        UIM_MODEM = 4'h9, UIM_TX_TRIG = 4'ha, UIM_TX_NFULL = 4'hb,
        UIM_TX_OVR = 4'hc
    } uim_bit_e;
    typedef enum logic [1:0] {
        UIM_W_IDLE = 2'h0, UIM_W_RESP = 2'h1
    } uim_wstate_e;
endpackage

// ---- design/uim_enable_reg.sv ----
// Purpose: per-source enable bits with set and clear strobes
// Assumes: strobes are one-cycle pulses
// Notes: clear wins over set on the same bit
`include "uim_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module uim_enable_reg (
    input wire logic clk,
    input wire logic nrst,
    input wire logic set_stb,
    input wire logic clr_stb,
    input wire uim_pkg::uim_src_t wr_bits,
    output uim_pkg::uim_src_t enabled
);
    uim_pkg::uim_src_t en_r;
    uim_pkg::uim_src_t en_nxt;
    genvar i;
    generate
        for (i = 0; i < `UIM_SRC_W; i++) begin : g_bit
            always_comb begin
                en_nxt[i] = en_r[i];
                if (set_stb && wr_bits[i]) begin
                    en_nxt[i] = 1'b1;
                end
                if (clr_stb && wr_bits[i]) begin
                    en_nxt[i] = 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (!nrst) begin
            en_r <= `UIM_SRC_RESET;
        end else begin
            en_r <= en_nxt;
        end
    end
    assign enabled = en_r;
    a_clear_drops: assert property (@(posedge clk)
        disable iff (!nrst)
        clr_stb |=> ((en_r & $past(wr_bits)) == '0))
        else $error("disable write left a bit enabled");
    a_zero_keeps: assert property (@(posedge clk)
        disable iff (!nrst)
        (set_stb || clr_stb) |=> ((en_r & ~$past(wr_bits)) ==
        ($past(en_r) & ~$past(wr_bits))))
        else $error("zero bit changed enable state");
endmodule // uim_enable_reg
`default_nettype wire

// ---- design/uim_irq_gate.sv ----
// Purpose: combine event status with enable bits
// Assumes: status bits held by the caller
// Notes: single level output, registered
`include "uim_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module uim_irq_gate (
    input wire logic clk,
    input wire logic nrst,
    input wire uim_pkg::uim_src_t status,
    input wire uim_pkg::uim_src_t enabled,
    output logic irq
);
    logic irq_r;
    logic irq_nxt;
    always_comb begin
        irq_nxt = |(status & enabled);
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end
    assign irq = irq_r;
    a_irq_follows: assert property (@(posedge clk)
        disable iff (!nrst)
        ##1 (irq == $past(|(status & enabled))))
        else $error("interrupt output does not follow enabled status");
endmodule // uim_irq_gate
`default_nettype wire

// ---- verification/uim_top_tb.sv ----
// Purpose: self-checking bench for the interrupt mask register block
// Assumes: AXI4-Lite master in the bench, second instance base decoded
// Notes: reset view read, then table of register accesses, then irq and reset cases
`include "uim_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module uim_top_tb;
    localparam logic [31:0] B = `UIM_BASE_SECOND;
    localparam logic [31:0] F = `UIM_BASE_FIRST;
    localparam logic [31:0] EN = B + {20'h0, `UIM_OFF_ENABLE};
    localparam logic [31:0] DIS = B + {20'h0, `UIM_OFF_DISABLE};
    localparam logic [31:0] VW = B + {20'h0, `UIM_OFF_VIEW};
    localparam logic [31:0] ST = B + {20'h0, `UIM_OFF_STATUS};
    localparam logic [1:0] OK = `UIM_RESP_OKAY;
    localparam logic [1:0] ER = `UIM_RESP_SLVERR;
    typedef struct {
        logic wr;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
        logic [1:0] resp;
    } uim_row_s;
    logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, rdat;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [`UIM_SRC_W-1:0] event_pulse;
    int n_errors = 0;
    int total_checks = 0;
    // 0x18 is unmapped; the first base belongs to the other instance
    uim_row_s rows [19] = '{
        '{1'b1, EN, 32'hffffffff, 4'hf, OK}, '{1'b0, VW, 32'h1fff, 4'h0, OK},
        '{1'b1, DIS, 32'h1081, 4'hf, OK}, '{1'b0, VW, 32'h0f7e, 4'h0, OK},
        '{1'b1, DIS, 32'hffffe000, 4'hf, OK}, '{1'b0, VW, 32'h0f7e, 4'h0, OK},
        '{1'b1, EN, 32'h0, 4'hf, OK}, '{1'b0, VW, 32'h0f7e, 4'h0, OK},
        '{1'b1, VW, 32'h0, 4'hf, OK}, '{1'b0, VW, 32'h0f7e, 4'h0, OK},
        '{1'b0, EN, 32'h0, 4'h0, OK}, '{1'b0, DIS, 32'h0, 4'h0, OK},
        '{1'b1, DIS, 32'h1fff, 4'hf, OK}, '{1'b1, EN, 32'h1fff, 4'h1, OK},
        '{1'b0, VW, 32'h00ff, 4'h0, OK}, '{1'b1, B + 32'h18, 32'h1, 4'hf, ER},
        '{1'b0, B + 32'h18, 32'h0, 4'h0, ER},
        '{1'b1, F + 32'h8, 32'h1fff, 4'hf, ER},
        '{1'b0, VW, 32'h00ff, 4'h0, OK}
    };

    uim_top #(.BASE_ADDR(B)) DUT (
        .clk(clk),
        .nrst(nrst),
        .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid),
        .s_axi_awready(awready),
        .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid),
        .s_axi_wready(wready),
        .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid),
        .s_axi_bready(bready),
        .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid),
        .s_axi_arready(arready),
        .s_axi_rdata(rdata),
        .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid),
        .s_axi_rready(rready),
        .event_pulse(event_pulse),
        .irq(irq)
    );

    // ****************************************
    // bench tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic time_out();
        n_errors++;
        end_of_test();
    endtask

    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
        int i;
        bit aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        for (i = 0; i < 50 && !(aw_ok && w_ok); i++) begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        if (!(aw_ok && w_ok)) time_out();
        // raised here so that back-to-back calls never assign it twice
        bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (bvalid === 1'b1) break;
        end
        if (i == 50) time_out();
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int i;
        araddr <= a;
        arvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (arready === 1'b1) break;
        end
        if (i == 50) time_out();
        arvalid <= 1'b0;
        rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (rvalid === 1'b1) break;
        end
        if (i == 50) time_out();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wait_irq(input logic v);
        int i;
        for (i = 0; i < 20 && irq !== v; i++) @(posedge clk);
        if (irq !== v) time_out();
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        nrst = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, wdata, araddr} = {3{32'h0}};
        wstrb = 4'h0;
        event_pulse = '0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        axi_rd(VW, rdat, resp);
        check(rdat, 32'h0);
        for (int k = 0; k < 19; k++) begin
            if (rows[k].wr)
                axi_wr(rows[k].addr, rows[k].data, rows[k].strb, resp);
            else axi_rd(rows[k].addr, rdat, resp);
            check({30'h0, resp}, {30'h0, rows[k].resp});
            if (!rows[k].wr && rows[k].resp === OK)
                check(rdat, rows[k].data);
        end
        // a pending event must stay silent while its source is disabled
        axi_wr(DIS, 32'h1fff, 4'hf, resp);
        event_pulse <= 13'h0008;
        @(posedge clk);
        event_pulse <= '0;
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        axi_rd(ST, rdat, resp);
        check(rdat, 32'h8);
        axi_wr(EN, 32'h8, 4'hf, resp);
        wait_irq(1'b1);
        check({31'h0, irq}, 32'h1);
        axi_wr(DIS, 32'h8, 4'hf, resp);
        wait_irq(1'b0);
        check({31'h0, irq}, 32'h0);
        axi_wr(EN, 32'h8, 4'hf, resp);
        wait_irq(1'b1);
        axi_wr(ST, 32'h8, 4'hf, resp);
        wait_irq(1'b0);
        check({31'h0, irq}, 32'h0);
        // second reset in mid-run with sources enabled and an event pending
        axi_wr(EN, 32'h1fff, 4'hf, resp);
        event_pulse <= 13'h1000;
        @(posedge clk);
        event_pulse <= '0;
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        check({31'h0, irq}, 32'h0);
        axi_rd(VW, rdat, resp);
        check(rdat, 32'h0);
        end_of_test();
    end
endmodule // uim_top_tb
`default_nettype wire
